/* rtl/i2cdac_map.svh */
// Constants for the two-wire DAC control port
`ifndef I2CDAC_MAP_SVH
`define I2CDAC_MAP_SVH

// ====================================================
// Target address
`define I2CDAC_ADDR6_FIXED 6'h06
`define I2CDAC_ADDR5_FIXED 5'h03

// ====================================================
// Control word fields
`define I2CDAC_WORD_RESET 16'h0000
`define I2CDAC_MODE_HI_BIT 13
`define I2CDAC_MODE_LO_BIT 12
`define I2CDAC_CODE_MSB 11

// ====================================================
// Power mode encodings
`define I2CDAC_MODE_NORMAL 2'h0
`define I2CDAC_MODE_1K 2'h1
`define I2CDAC_MODE_100K 2'h2
`define I2CDAC_MODE_TRISTATE 2'h3

// ====================================================
// Byte framing
`define I2CDAC_BITS_PER_BYTE 4'h8

`endif

/* rtl/i2cdac_pkg.sv */
// Types for the two-wire DAC control port
package i2cdac_pkg;

   // ====================================================
   // Bus state
   typedef enum logic [2:0] {
      I2CDAC_IDLE,
      I2CDAC_ADDR,
      I2CDAC_ADDR_ACK,
      I2CDAC_WR_BYTE,
      I2CDAC_WR_ACK,
      I2CDAC_RD_BYTE,
      I2CDAC_RD_ACK,
      I2CDAC_IGNORE
   } i2cdac_state_t;

endpackage

/* rtl/i2cdac_port.sv */
// Two-wire target port and control word register of a single-channel DAC
//
// Notes on behaviour
// - Six-lead: address is 000110 then the low select pin.
// - Eight-lead: address is 00011 then both select pins.
// - Target only; the clock line is never driven or held.
// - Start is data falling while clock high; next byte is address.
// - Direction bit high means read, low means write.
// - Matching address is acknowledged by pulling data low on ninth pulse.
// - Non-matching address: stay off the data line until next start.
// - Bytes are eight bits MSB first plus one acknowledge from receiver.
// - Data line changes only while clock low, except start and stop.
// - Stop is data rising while clock high; the bus is then released.
// - In a read a missing acknowledge ends transmission before stop.
// - Writes carry two data bytes; reads return one or two bytes.
// - Each further byte pair while addressed loads a new word.
// - Reads may be repeated and return the readback again.
// - Write data shifts into a 16-bit register on the clock, bit 15 first.
// - Top two bits ignored; next two select power mode.
// - Left-justified code of 8, 10 or 12 bits follows the mode bits.
// - Code is straight binary over the full range of its width.
// - Register clears to zero at reset until a valid write completes.
// - Eight-bit variant reads back one byte of code bits.
// - Ten and twelve-bit variants read back two bytes with mode bits.
// - Mode 00 normal, 01 1k low, 10 100k low, 11 three-state.
// - Eight-lead only: low power-down pin forces three-state, overriding the word.
// - Power-down never changes the stored code.
`timescale 1ns/1ns
`default_nettype none
`include "i2cdac_map.svh"

module i2cdac_port
   import i2cdac_pkg::*;
#(
   parameter int DAC_BITS = 12,
   parameter bit EIGHT_LEAD = 1'b1
) (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic scl_clk_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic addr_select_low_i,
   input wire logic addr_select_second_i,
   input wire logic hw_powerdown_n_i,
   output logic [DAC_BITS-1:0] dac_code_o,
   output logic [1:0] power_mode_o,
   output logic dac_update_o,
   output logic addressed_o
);

   // ====================================================
   // Functions
   function automatic logic addr_match(input logic [6:0] addr, input logic a1, input logic a0);
      logic hit;
      hit = 1'b0;
      if (EIGHT_LEAD) begin
         hit = (addr == {`I2CDAC_ADDR5_FIXED, a1, a0});
      end else begin
         hit = (addr == {`I2CDAC_ADDR6_FIXED, a0});
      end
      return hit;
   endfunction

   function automatic logic [7:0] readback_byte(input logic [15:0] word, input logic idx);
      logic [7:0] b;
      b = 8'h00;
      if (DAC_BITS == 8) begin
         b = word[`I2CDAC_CODE_MSB -: 8];
      end else if (idx == 1'b0) begin
         b = {2'b00, word[`I2CDAC_MODE_HI_BIT:8]};
      end else begin
         b = word[7:0];
      end
      return b;
   endfunction

   // ====================================================
   // Reset release
   logic [1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ====================================================
   // Link domain: serial shift register clocked by the bus clock
   logic [15:0] link_shift_q;

   always_ff @(posedge scl_clk_i) begin
      link_shift_q <= {link_shift_q[14:0], sda_i};
   end

   // ====================================================
   // Pin synchronisers
   logic [2:0] scl_sync_q;
   logic [2:0] sda_sync_q;
   logic [1:0] a0_sync_q;
   logic [1:0] a1_sync_q;
   logic [1:0] pd_sync_q;

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         scl_sync_q <= 3'h7;
         sda_sync_q <= 3'h7;
         a0_sync_q <= 2'h0;
         a1_sync_q <= 2'h0;
         pd_sync_q <= 2'h3;
      end else begin
         scl_sync_q <= {scl_sync_q[1:0], scl_clk_i};
         sda_sync_q <= {sda_sync_q[1:0], sda_i};
         a0_sync_q <= {a0_sync_q[0], addr_select_low_i};
         a1_sync_q <= {a1_sync_q[0], addr_select_second_i};
         pd_sync_q <= {pd_sync_q[0], hw_powerdown_n_i};
      end
   end

   // ====================================================
   // Bus events
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   assign scl_rise = scl_sync_q[1] & ~scl_sync_q[2];
   assign scl_fall = ~scl_sync_q[1] & scl_sync_q[2];
   assign start_seen = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[1] & sda_sync_q[2];
   assign stop_seen = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[1] & ~sda_sync_q[2];

   // ====================================================
   // Protocol state
   i2cdac_state_t state_q;
   i2cdac_state_t state_d;
   logic [3:0] bit_cnt_q;
   logic byte_full;
   logic read_q;
   logic pair_idx_q;
   logic rd_idx_q;
   logic master_ack_q;
   logic [7:0] tx_q;
   logic [7:0] hi_byte_q;
   logic [15:0] dac_control_word_q;
   logic commit;
   logic rd_load;
   logic commit_q;
   logic [7:0] rd_byte;

   assign byte_full = (bit_cnt_q == `I2CDAC_BITS_PER_BYTE);
   assign commit = (state_q == I2CDAC_WR_BYTE) && scl_fall && byte_full && pair_idx_q;
   assign rd_load = scl_fall && (((state_q == I2CDAC_ADDR_ACK) && read_q)
                     || ((state_q == I2CDAC_RD_ACK) && master_ack_q));
   assign rd_byte = readback_byte(dac_control_word_q, rd_idx_q);

   always_comb begin
      state_d = state_q;
      if (stop_seen) begin
         state_d = I2CDAC_IDLE;
      end else if (start_seen) begin
         state_d = I2CDAC_ADDR;
      end else if (scl_fall) begin
         unique case (state_q)
            I2CDAC_IDLE: begin
               state_d = I2CDAC_IDLE;
            end
            I2CDAC_ADDR: begin
               if (byte_full) begin
                  if (addr_match(link_shift_q[7:1], a1_sync_q[1], a0_sync_q[1])) begin
                     state_d = I2CDAC_ADDR_ACK;
                  end else begin
                     state_d = I2CDAC_IGNORE;
                  end
               end
            end
            I2CDAC_ADDR_ACK: begin
               state_d = read_q ? I2CDAC_RD_BYTE : I2CDAC_WR_BYTE;
            end
            I2CDAC_WR_BYTE: begin
               if (byte_full) begin
                  state_d = I2CDAC_WR_ACK;
               end
            end
            I2CDAC_WR_ACK: begin
               state_d = I2CDAC_WR_BYTE;
            end
            I2CDAC_RD_BYTE: begin
               if (byte_full) begin
                  state_d = I2CDAC_RD_ACK;
               end
            end
            I2CDAC_RD_ACK: begin
               state_d = master_ack_q ? I2CDAC_RD_BYTE : I2CDAC_IGNORE;
            end
            I2CDAC_IGNORE: begin
               state_d = I2CDAC_IGNORE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= I2CDAC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Bit counter counts clock rises within the current byte
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_q <= 4'h0;
      end else if (start_seen || stop_seen) begin
         bit_cnt_q <= 4'h0;
      end else if (scl_fall && (byte_full || state_q == I2CDAC_ADDR_ACK
                                || state_q == I2CDAC_WR_ACK || state_q == I2CDAC_RD_ACK)) begin
         bit_cnt_q <= 4'h0;
      end else if (scl_rise && !byte_full) begin
         bit_cnt_q <= bit_cnt_q + 4'h1;
      end
   end

   // Direction bit of the address byte
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         read_q <= 1'b0;
      end else if (state_q == I2CDAC_ADDR && scl_fall && byte_full) begin
         read_q <= link_shift_q[0];
      end
   end

   // Master acknowledge sampled on the ninth pulse of a read byte
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         master_ack_q <= 1'b0;
      end else if (state_q == I2CDAC_RD_ACK && scl_rise) begin
         master_ack_q <= ~sda_sync_q[1];
      end
   end

   // ====================================================
   // Write path: byte pairing and control word
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pair_idx_q <= 1'b0;
      end else if (start_seen || stop_seen || state_q == I2CDAC_ADDR) begin
         pair_idx_q <= 1'b0;
      end else if (state_q == I2CDAC_WR_BYTE && scl_fall && byte_full) begin
         pair_idx_q <= ~pair_idx_q;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         hi_byte_q <= 8'h00;
      end else if (state_q == I2CDAC_WR_BYTE && scl_fall && byte_full && !pair_idx_q) begin
         hi_byte_q <= link_shift_q[7:0];
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dac_control_word_q <= `I2CDAC_WORD_RESET;
      end else if (commit) begin
         dac_control_word_q <= {2'b00, hi_byte_q[5:0], link_shift_q[7:0]};
      end
   end

   // ====================================================
   // Read path: byte to transmit
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rd_idx_q <= 1'b0;
      end else if (state_q == I2CDAC_ADDR) begin
         rd_idx_q <= 1'b0;
      end else if (rd_load && DAC_BITS != 8) begin
         rd_idx_q <= ~rd_idx_q;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tx_q <= 8'hff;
      end else if (rd_load) begin
         tx_q <= {rd_byte[6:0], 1'b1};
      end else if (state_q == I2CDAC_RD_BYTE && scl_fall && !byte_full) begin
         tx_q <= {tx_q[6:0], 1'b1};
      end
   end

   // ====================================================
   // Data line drive, changed only after a clock fall
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sda_oe_n_o <= 1'b1;
      end else if (start_seen || stop_seen) begin
         sda_oe_n_o <= 1'b1;
      end else if (scl_fall) begin
         if (state_q == I2CDAC_ADDR && byte_full) begin
            sda_oe_n_o <= ~addr_match(link_shift_q[7:1], a1_sync_q[1], a0_sync_q[1]);
         end else if (state_q == I2CDAC_WR_BYTE && byte_full) begin
            sda_oe_n_o <= 1'b0;
         end else if (rd_load) begin
            sda_oe_n_o <= rd_byte[7];
         end else if (state_q == I2CDAC_RD_BYTE && !byte_full) begin
            sda_oe_n_o <= tx_q[7];
         end else begin
            sda_oe_n_o <= 1'b1;
         end
      end
   end

   // Open-drain: the line is only ever pulled low, the clock never driven
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   // ====================================================
   // DAC side outputs
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dac_code_o <= '0;
      end else begin
         dac_code_o <= dac_control_word_q[`I2CDAC_CODE_MSB -: DAC_BITS];
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         power_mode_o <= `I2CDAC_MODE_NORMAL;
      end else if (EIGHT_LEAD && !pd_sync_q[1]) begin
         power_mode_o <= `I2CDAC_MODE_TRISTATE;
      end else begin
         power_mode_o <= dac_control_word_q[`I2CDAC_MODE_HI_BIT:`I2CDAC_MODE_LO_BIT];
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dac_update_o <= 1'b0;
      end else begin
         dac_update_o <= commit_q;
      end
   end

   // Strobe delayed so that it rises with the new code on the outputs
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         commit_q <= 1'b0;
      end else begin
         commit_q <= commit;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         addressed_o <= 1'b0;
      end else begin
         addressed_o <= (state_d != I2CDAC_IDLE) && (state_d != I2CDAC_IGNORE)
                        && (state_d != I2CDAC_ADDR);
      end
   end

endmodule
`default_nettype wire

/* testbench/i2cdac_port_properties.sv */
// Concurrent checks on the DAC control port
`timescale 1ns/1ns
`default_nettype none
module i2cdac_port_checker #(
   parameter int DAC_BITS = 12,
   parameter bit EIGHT_LEAD = 1'b1
) (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic scl_clk_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire logic hw_powerdown_n_i,
   input wire logic [DAC_BITS-1:0] dac_code_o,
   input wire logic [1:0] power_mode_o,
   input wire logic dac_update_o,
   input wire logic addressed_o
);
   // ==================================================
   // Properties
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   property p_update_pulse; dac_update_o |=> !dac_update_o; endproperty
   a_update_pulse: assert property (p_update_pulse) else $error("update pulse too long");
   property p_code_hold; !dac_update_o |-> $stable(dac_code_o); endproperty
   a_code_hold: assert property (p_code_hold) else $error("code moved without commit");
   property p_pd_force; (EIGHT_LEAD && !hw_powerdown_n_i) [*8] |-> power_mode_o == 2'h3; endproperty
   a_pd_force: assert property (p_pd_force) else $error("power-down pin not obeyed");
   property p_oe_scl_low; $changed(sda_oe_n_o) |-> !scl_clk_i; endproperty
   a_oe_scl_low: assert property (p_oe_scl_low) else $error("data drive moved with clock high");
   property p_drive_addressed; !sda_oe_n_o |-> ##[0:2] addressed_o; endproperty
   a_drive_addressed: assert property (p_drive_addressed) else $error("data driven while not addressed");
   property p_update_addressed; dac_update_o |-> addressed_o; endproperty
   a_update_addressed: assert property (p_update_addressed) else $error("commit while not addressed");
   property p_stop_release; scl_clk_i && $rose(sda_i) |-> ##[1:8] (!addressed_o && sda_oe_n_o); endproperty
   a_stop_release: assert property (p_stop_release) else $error("bus not released after stop");
   property p_reset_vals;
      $rose(arst_n_i) |-> dac_code_o == '0 && power_mode_o == 2'h0 && sda_oe_n_o && !addressed_o;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad values after reset");
   property p_sda_zero; !sda_oe_n_o |-> sda_o == 1'b0; endproperty
   a_sda_zero: assert property (p_sda_zero) else $error("driven data not low");
   c_update: cover property (dac_update_o);
   c_drive: cover property (!sda_oe_n_o && addressed_o);
   c_tristate: cover property (power_mode_o == 2'h3);
endmodule

bind i2cdac_port i2cdac_port_checker #(.DAC_BITS(DAC_BITS), .EIGHT_LEAD(EIGHT_LEAD)) i2cdac_port_checker_inst (
   .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .scl_clk_i(scl_clk_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_n_o(sda_oe_n_o), .hw_powerdown_n_i(hw_powerdown_n_i), .dac_code_o(dac_code_o),
   .power_mode_o(power_mode_o), .dac_update_o(dac_update_o), .addressed_o(addressed_o));
`default_nettype wire

/* testbench/i2cdac_master_model.sv */
// Bus master model for the DAC control port
`timescale 1ns/1ns
`default_nettype none
module i2cdac_master_model (
   input wire logic link_clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   // ==================================================
   // Bus cycles
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic ticks(input int n);
      repeat (n) @(posedge link_clk_i);
   endtask
   task automatic pulse(input logic b, output logic r);
      scl_o <= 1'b0;
      ticks(8);
      sda_low_o <= !b;
      ticks(9);
      scl_o <= 1'b1;
      ticks(8);
      r = sda_i;
      ticks(9);
   endtask
   task automatic start();
      ticks(1);
      sda_low_o <= 1'b1;
      ticks(9);
   endtask
   task automatic stop();
      scl_o <= 1'b0;
      ticks(8);
      sda_low_o <= 1'b1;
      ticks(9);
      scl_o <= 1'b1;
      ticks(9);
      sda_low_o <= 1'b0;
      ticks(9);
   endtask
   task automatic xfer(input logic [7:0] tx, input logic rd, input logic mack, output logic [7:0] rx,
                       output logic ack);
      for (int i = 7; i >= 0; i--) begin
         pulse(rd | tx[i], rx[i]);
      end
      pulse(rd ? mack : 1'b1, ack);
   endtask
endmodule
`default_nettype wire

/* testbench/i2cdac_port_tb.sv */
// Self-checking bench for the DAC control port
`timescale 1ns/1ns
`default_nettype none
module i2cdac_port_tb;
   logic core_clk = 1'b0;
   logic link_clk = 1'b1;
   logic arst_n = 1'b0;
   logic a0 = 1'b0;
   logic a1 = 1'b1;
   logic pd_n = 1'b1;
   logic scl, m_low, sda_o, sda_oe_n, upd, addressed;
   logic sda_oe_n8;
   logic [7:0] code8;
   logic [1:0] mode8;
   logic [11:0] code;
   logic [1:0] mode;
   logic [7:0] rx;
   logic ack;
   logic [15:0] last = 16'h0000;
   int fail_count = 0;
   int checks_done = 0;
   int upd_seen = 0;
   wire logic sda = !(m_low || !sda_oe_n || !sda_oe_n8);
   always #5 core_clk = ~core_clk;
   always #3 link_clk = ~link_clk;
   always @(posedge core_clk) upd_seen <= upd_seen + int'(upd);

   i2cdac_port i2cdac_port_inst (.core_clk_i(core_clk), .arst_n_i(arst_n), .scl_clk_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .addr_select_low_i(a0), .addr_select_second_i(a1),
      .hw_powerdown_n_i(pd_n), .dac_code_o(code), .power_mode_o(mode), .dac_update_o(upd),
      .addressed_o(addressed));
   i2cdac_port #(.DAC_BITS(8), .EIGHT_LEAD(1'b0)) i2cdac_port_inst_six (.core_clk_i(core_clk), .arst_n_i(arst_n),
      .scl_clk_i(scl), .sda_i(sda), .sda_o(), .sda_oe_n_o(sda_oe_n8), .addr_select_low_i(a0),
      .addr_select_second_i(a1), .hw_powerdown_n_i(pd_n), .dac_code_o(code8), .power_mode_o(mode8),
      .dac_update_o(), .addressed_o());
   i2cdac_master_model master (.link_clk_i(link_clk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

   // ==================================================
   // Helpers
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic addr(input logic [6:0] a, input logic rd, input logic exp_ack);
      master.start();
      master.xfer({a, rd}, 1'b0, 1'b1, rx, ack);
      chk("address ack", exp_ack, ack);
      chk("addressed", !exp_ack, addressed);
   endtask
   task automatic send_word(input logic [15:0] w);
      master.xfer(w[15:8], 1'b0, 1'b1, rx, ack);
      chk("first byte ack", 0, ack);
      master.xfer(w[7:0], 1'b0, 1'b1, rx, ack);
      chk("second byte ack", 0, ack);
      last = {2'b00, w[13:0]};
      chk("code", last[11:0], code);
      chk("mode", last[13:12], mode);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ==================================================
   // Scenarios
   task automatic test_write();
      int n;
      n = upd_seen;
      addr(7'h0e, 1'b0, 1'b0);
      for (int m = 0; m < 4; m++) begin
         send_word({2'b11, 2'(3 - m), 12'h9c3 ^ 12'(m * 273)});
      end
      master.stop();
      repeat (8) @(posedge core_clk);
      chk("updates", 4, 16'(upd_seen - n));
      chk("released", 1, sda_oe_n);
      chk("not addressed", 0, addressed);
      $display("write test done");
   endtask
   task automatic test_abort();
      addr(7'h0e, 1'b0, 1'b0);
      master.xfer(8'h15, 1'b0, 1'b1, rx, ack);
      master.stop();
      chk("odd byte", last[11:0], code);
      addr(7'h0e, 1'b0, 1'b0);
      repeat (4) master.pulse(1'b0, ack);
      master.stop();
      chk("mid byte stop", last[11:0], code);
      $display("abort test done");
   endtask
   task automatic test_wrong();
      addr(7'h0d, 1'b0, 1'b1);
      master.xfer(8'h3f, 1'b0, 1'b1, rx, ack);
      chk("no ack", 1, ack);
      master.xfer(8'hff, 1'b0, 1'b1, rx, ack);
      master.stop();
      chk("foreign write", last[11:0], code);
      $display("wrong address test done");
   endtask
   task automatic test_pins();
      @(posedge core_clk) a0 <= 1'b1;
      repeat (4) @(posedge core_clk);
      addr(7'h0f, 1'b0, 1'b0);
      send_word(16'h5abc);
      master.stop();
      addr(7'h0e, 1'b0, 1'b1);
      master.stop();
      $display("address pin test done");
   endtask
   task automatic test_read();
      for (int r = 0; r < 2; r++) begin
         addr(7'h0f, 1'b1, 1'b0);
         master.xfer(8'hff, 1'b1, 1'b0, rx, ack);
         chk("read byte 0", last[15:8], rx);
         master.xfer(8'hff, 1'b1, 1'b1, rx, ack);
         chk("read byte 1", last[7:0], rx);
         master.stop();
      end
      $display("read test done");
   endtask
   task automatic test_pd();
      @(posedge core_clk) pd_n <= 1'b0;
      repeat (10) @(posedge core_clk);
      chk("forced mode", 3, mode);
      chk("code kept", last[11:0], code);
      pd_n <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk("mode back", last[13:12], mode);
      $display("power-down pin test done");
   endtask
   task automatic test_six();
      @(posedge core_clk) pd_n <= 1'b0;
      chk("six-lead idle", 0, code8);
      master.start();
      master.xfer({7'h0d, 1'b0}, 1'b0, 1'b1, rx, ack);
      chk("six-lead address ack", 0, ack);
      master.xfer(8'h27, 1'b0, 1'b1, rx, ack);
      master.xfer(8'h5a, 1'b0, 1'b1, rx, ack);
      chk("six-lead data ack", 0, ack);
      master.stop();
      chk("six-lead code", 8'h75, code8);
      chk("six-lead mode", 2, mode8);
      master.start();
      master.xfer({7'h0d, 1'b1}, 1'b0, 1'b1, rx, ack);
      master.xfer(8'hff, 1'b1, 1'b1, rx, ack);
      chk("six-lead read", 8'h75, rx);
      master.stop();
      @(posedge core_clk) pd_n <= 1'b1;
      $display("six-lead test done");
   endtask

   initial begin
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk("reset code", 0, code);
      chk("reset drive", 1, sda_oe_n);
      test_write();
      test_abort();
      test_wrong();
      test_pins();
      test_read();
      test_pd();
      test_six();
      stop_test();
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      fail_count++;
      stop_test();
   end
endmodule
`default_nettype wire
